// ===== hdl/rms_pin_sync.sv
`default_nettype none
module rms_pin_sync
   import rms_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // raw pin
   input wire logic pin_in,
   // filtered level
   rms_sync_if.src sync
);
   typedef struct packed
   {
      logic [2:0] chain;
      logic lvl;
   } rms_sync_s;

   rms_sync_s cur_ff;
   rms_sync_s nxt_cur;

   // no reset: the chain must keep tracking the pin while reset is held,
   // otherwise the mode level would be lost at the release
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.chain = {cur_ff.chain[1:0], pin_in};
      if (cur_ff.chain[1] == cur_ff.chain[2])
      begin
         nxt_cur.lvl = cur_ff.chain[2];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      cur_ff <= nxt_cur;
   end

   assign sync.pin_lvl = cur_ff.lvl;
endmodule : rms_pin_sync
`default_nettype wire

// ===== hdl/rms_pkg.sv
`default_nettype none
package rms_pkg;
   // top of memory holds the reset vector, high byte first
   localparam logic [15:0] RMS_VEC_HI_ADDR = 16'hfffe;
   localparam logic [15:0] RMS_VEC_LO_ADDR = 16'hffff;
   // one bit time on the debug link, in debug clock cycles (= ref_clk here)
   localparam int RMS_BIT_CYC = 16;
   localparam logic [4:0] RMS_BIT_LAST = 5'(RMS_BIT_CYC - 1);
   localparam logic [4:0] RMS_LOW_ONE = 5'h04;
   localparam logic [4:0] RMS_LOW_ZERO = 5'h0d;
   localparam logic [4:0] RMS_SAMPLE_AT = 5'h0a;
   localparam int RMS_GPIO_N = 37;
   localparam logic RMS_SYNC_RST_VAL = 1'b1;

   typedef enum logic [5:0]
   {
      RMS_ST_RST = 6'h01,
      RMS_ST_FETCH_HI = 6'h02,
      RMS_ST_FETCH_LO = 6'h04,
      RMS_ST_START = 6'h08,
      RMS_ST_RUN = 6'h10,
      RMS_ST_BACKGROUND = 6'h20
   } rms_state_e;
endpackage : rms_pkg
`default_nettype wire

// ===== hdl/rms_sync_if.sv
`default_nettype none
interface rms_sync_if;
   logic pin_lvl;
   modport src (output pin_lvl);
   modport dst (input pin_lvl);
endinterface : rms_sync_if
`default_nettype wire

// ===== hdl/rms_top.sv
// Operation
// - during reset the shared debug pin is only a mode-select input
// - once reset releases, the pin becomes the single-wire debug line
// - pullup stays on whenever the pin is debug or mode-select line
// - pin becomes output-only port bit only when debug pin enable is cleared
// - pin low at reset release enters active background mode
// - pin high or floating at reset release enters normal run mode
// - run mode starts at the big-endian vector from the top two bytes
// - each debug bit time lasts sixteen debug clock cycles
// - releasing the line after low drives a brief high speedup pulse
// - after reset all general-purpose pins are inputs, pullups off
// - halt command, halt instruction or breakpoints in run mode also enter background mode
`default_nettype none
module rms_top
   import rms_pkg::*;
#(
   parameter int GPIO_N = RMS_GPIO_N
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // shared debug / mode select pin
   input wire logic debug_mode_select_pin_in,
   output logic debug_mode_select_pin_out,
   output logic debug_mode_select_pin_oe,
   output logic debug_mode_select_pin_pullup_en,
   // system options
   input wire logic debug_pin_enable,
   input wire logic port_d_bit_zero,
   // debug controller bit requests
   input wire logic tx_bit_start,
   input wire logic tx_bit_val,
   output logic tx_busy,
   output logic rx_bit,
   output logic rx_valid,
   // halt sources
   input wire logic halt_cmd,
   input wire logic halt_to_debug_instruction,
   input wire logic background_debug_controller_breakpoint,
   input wire logic trace_breakpoint_unit,
   // vector fetch
   output logic mem_rd,
   output logic [15:0] mem_addr,
   input wire logic mem_rvalid,
   input wire logic [7:0] mem_rdata,
   output logic cpu_start,
   output logic [15:0] cpu_start_pc,
   output logic bg_mode,
   // general-purpose pin defaults
   input wire logic gpio_cfg_wr,
   input wire logic [GPIO_N-1:0] gpio_cfg_oe,
   input wire logic [GPIO_N-1:0] gpio_cfg_pu,
   output logic [GPIO_N-1:0] gpio_oe,
   output logic [GPIO_N-1:0] gpio_pullup_en
);
   typedef struct packed
   {
      rms_state_e st;
      logic bg;
      logic [15:0] pc;
      logic start;
      logic rd;
      logic [15:0] addr;
      logic busy;
      logic [4:0] cnt;
      logic [4:0] low_len;
      logic rxb;
      logic rxv;
      logic pout;
      logic poe;
      logic ppu;
      logic [GPIO_N-1:0] goe;
      logic [GPIO_N-1:0] gpu;
   } rms_state_s;

   rms_state_s cur_ff;
   rms_state_s nxt_cur;
   rms_sync_if sync_bus ();

   rms_pin_sync u_sync
   (
      .ref_clk(ref_clk),
      .pin_in(debug_mode_select_pin_in),
      .sync(sync_bus.src)
   );

   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.start = 1'b0;
      nxt_cur.rd = 1'b0;
      nxt_cur.rxv = 1'b0;
      if (!nrst)
      begin
         nxt_cur.st = RMS_ST_RST;
         nxt_cur.bg = 1'b0;
         nxt_cur.pc = 16'h0000;
         nxt_cur.addr = 16'h0000;
         nxt_cur.busy = 1'b0;
         nxt_cur.cnt = 5'h00;
         nxt_cur.low_len = 5'h00;
         nxt_cur.rxb = 1'b0;
         // pin is a plain input with pullup while in reset
         nxt_cur.pout = 1'b0;
         nxt_cur.poe = 1'b0;
         nxt_cur.ppu = 1'b1;
         nxt_cur.goe = '0;
         nxt_cur.gpu = '0;
      end
      else
      begin
         unique case (cur_ff.st)
            RMS_ST_RST:
            begin
               // single sample of the filtered level, first cycle out of reset
               if (!sync_bus.pin_lvl)
               begin
                  nxt_cur.st = RMS_ST_BACKGROUND;
                  nxt_cur.bg = 1'b1;
               end
               else
               begin
                  nxt_cur.st = RMS_ST_FETCH_HI;
                  nxt_cur.rd = 1'b1;
                  nxt_cur.addr = RMS_VEC_HI_ADDR;
               end
            end
            RMS_ST_FETCH_HI:
            begin
               if (mem_rvalid)
               begin
                  nxt_cur.pc[15:8] = mem_rdata;
                  nxt_cur.st = RMS_ST_FETCH_LO;
                  nxt_cur.rd = 1'b1;
                  nxt_cur.addr = RMS_VEC_LO_ADDR;
               end
            end
            RMS_ST_FETCH_LO:
            begin
               if (mem_rvalid)
               begin
                  nxt_cur.pc[7:0] = mem_rdata;
                  nxt_cur.st = RMS_ST_START;
               end
            end
            RMS_ST_START:
            begin
               nxt_cur.start = 1'b1;
               nxt_cur.st = RMS_ST_RUN;
            end
            RMS_ST_RUN:
            begin
               if (halt_cmd || halt_to_debug_instruction ||
                   background_debug_controller_breakpoint || trace_breakpoint_unit)
               begin
                  nxt_cur.st = RMS_ST_BACKGROUND;
                  nxt_cur.bg = 1'b1;
               end
            end
            RMS_ST_BACKGROUND:
            begin
               // held until the next reset
               nxt_cur.bg = 1'b1;
            end
         endcase

         // bit timer of the debug line
         if (cur_ff.busy)
         begin
            nxt_cur.cnt = cur_ff.cnt + 5'h01;
            if (cur_ff.cnt == RMS_SAMPLE_AT)
            begin
               nxt_cur.rxb = sync_bus.pin_lvl;
               nxt_cur.rxv = 1'b1;
            end
            if (cur_ff.cnt == RMS_BIT_LAST)
            begin
               nxt_cur.busy = 1'b0;
               nxt_cur.cnt = 5'h00;
            end
         end
         else if (tx_bit_start && debug_pin_enable)
         begin
            nxt_cur.busy = 1'b1;
            nxt_cur.cnt = 5'h00;
            nxt_cur.low_len = tx_bit_val ? RMS_LOW_ONE : RMS_LOW_ZERO;
         end

         if (debug_pin_enable)
         begin
            nxt_cur.ppu = 1'b1;
            nxt_cur.poe = 1'b0;
            nxt_cur.pout = 1'b0;
            if (nxt_cur.busy && (nxt_cur.cnt < nxt_cur.low_len))
            begin
               nxt_cur.poe = 1'b1;
            end
            else if (nxt_cur.busy && (nxt_cur.cnt == nxt_cur.low_len))
            begin
               // one cycle actively high so the line does not crawl up
               nxt_cur.poe = 1'b1;
               nxt_cur.pout = 1'b1;
            end
         end
         else
         begin
            nxt_cur.ppu = 1'b0;
            nxt_cur.poe = 1'b1;
            nxt_cur.pout = port_d_bit_zero;
            nxt_cur.busy = 1'b0;
            nxt_cur.cnt = 5'h00;
         end

         if (gpio_cfg_wr)
         begin
            nxt_cur.goe = gpio_cfg_oe;
            nxt_cur.gpu = gpio_cfg_pu;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      cur_ff <= nxt_cur;
   end

   assign debug_mode_select_pin_out = cur_ff.pout;
   assign debug_mode_select_pin_oe = cur_ff.poe;
   assign debug_mode_select_pin_pullup_en = cur_ff.ppu;
   assign tx_busy = cur_ff.busy;
   assign rx_bit = cur_ff.rxb;
   assign rx_valid = cur_ff.rxv;
   assign mem_rd = cur_ff.rd;
   assign mem_addr = cur_ff.addr;
   assign cpu_start = cur_ff.start;
   assign cpu_start_pc = cur_ff.pc;
   assign bg_mode = cur_ff.bg;
   assign gpio_oe = cur_ff.goe;
   assign gpio_pullup_en = cur_ff.gpu;
endmodule : rms_top
`default_nettype wire

// ===== tb/rms_pod.sv
`default_nettype none
module rms_pod
(
   // clock and pod request
   input wire logic ref_clk,
   input wire logic hold_low,
   // device side of the pin
   input wire logic dev_oe,
   input wire logic dev_out,
   input wire logic dev_pu,
   // resolved line
   output logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_ff = 1'b0;
   logic held_ff = 1'b0;
   // an undriven line with no pullup toggles, so no stale level is ever seen
   always_comb
      if (dev_oe)
         line = dev_out;
      else if (hold_low)
         line = 1'b0;
      else if (held_ff)
         line = 1'b1;
      else if (dev_pu)
         line = 1'b1;
      else
         line = ~last_ff;
   always_ff @(posedge ref_clk)
   begin
      last_ff <= line;
      held_ff <= hold_low;
   end
endmodule : rms_pod
`default_nettype wire

// ===== tb/rms_top_sva.sv
`default_nettype none
module rms_chk
   import rms_pkg::*;
#(
   parameter int GPIO_N = RMS_GPIO_N
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // shared pin
   input wire logic debug_mode_select_pin_in,
   input wire logic debug_mode_select_pin_out,
   input wire logic debug_mode_select_pin_oe,
   input wire logic debug_mode_select_pin_pullup_en,
   // controls
   input wire logic debug_pin_enable,
   input wire logic port_d_bit_zero,
   input wire logic tx_bit_start,
   input wire logic tx_busy,
   // mode, fetch and pins
   input wire logic mem_rd,
   input wire logic bg_mode,
   input wire logic [15:0] mem_addr,
   input wire logic [GPIO_N-1:0] gpio_oe,
   input wire logic [GPIO_N-1:0] gpio_pullup_en
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_rst_pin;
      $rose(nrst) |-> debug_mode_select_pin_pullup_en && !debug_mode_select_pin_oe;
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("pin not input");
   property p_rst_gpio; $rose(nrst) |-> gpio_oe == '0 && gpio_pullup_en == '0; endproperty
   a_rst_gpio: assert property (p_rst_gpio) else $error("gpio not default");
   property p_bg; $rose(nrst) && !debug_mode_select_pin_in |=> bg_mode && !mem_rd; endproperty
   a_bg: assert property (p_bg) else $error("no background entry");
   property p_run;
      $rose(nrst) && debug_mode_select_pin_in |=>
         mem_rd && mem_addr == RMS_VEC_HI_ADDR && !bg_mode;
   endproperty
   a_run: assert property (p_run) else $error("no vector fetch");
   property p_line;
      $rose(nrst) && debug_pin_enable |=>
         debug_mode_select_pin_pullup_en && !debug_mode_select_pin_oe;
   endproperty
   a_line: assert property (p_line) else $error("pin not debug line");
   property p_port;
      !debug_pin_enable |=> debug_mode_select_pin_oe && !debug_mode_select_pin_pullup_en &&
         debug_mode_select_pin_out == $past(port_d_bit_zero);
   endproperty
   a_port: assert property (p_port) else $error("port bit not driven");
   property p_bit;
      tx_bit_start && !tx_busy && debug_pin_enable |=> tx_busy[*8] ##1 tx_busy[*8] ##1 !tx_busy;
   endproperty
   a_bit: assert property (p_bit) else $error("bit time wrong");
   property p_speed;
      tx_busy && debug_mode_select_pin_oe && !debug_mode_select_pin_out ##1
         !(debug_mode_select_pin_oe && !debug_mode_select_pin_out) |->
         debug_mode_select_pin_oe && debug_mode_select_pin_out ##1 !debug_mode_select_pin_oe;
   endproperty
   a_speed: assert property (p_speed) else $error("no speedup pulse");
   c_bg: cover property ($rose(bg_mode));
   c_vec: cover property (mem_rd && mem_addr == RMS_VEC_LO_ADDR);
   c_bit: cover property ($fell(tx_busy));
endmodule : rms_chk
bind rms_top rms_chk #(.GPIO_N(GPIO_N)) u_chk (.ref_clk, .nrst, .debug_mode_select_pin_in,
   .debug_mode_select_pin_out, .debug_mode_select_pin_oe, .debug_mode_select_pin_pullup_en,
   .debug_pin_enable, .port_d_bit_zero, .tx_bit_start, .tx_busy, .mem_rd, .bg_mode, .mem_addr,
   .gpio_oe, .gpio_pullup_en);
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
   $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rms_pkg::*;
   logic ref_clk = 0, nrst = 0, hold = 0, dpe = 1, pd0 = 0, txs = 0, txv = 0, wr = 0, rv = 0;
   logic [3:0] halt = 4'h0;
   logic [7:0] rd = 8'h0;
   logic [RMS_GPIO_N-1:0] c_oe = '0, c_pu = '0, g_oe, g_pu;
   logic pin, pout, poe, ppu, busy, rxb, rxv, mrd, cst, bg, exp_bit;
   logic [15:0] maddr, pc;
   int failures = 0, compares = 0, cyc = 0;
   logic q[$];
   rms_top dut (
      .ref_clk(ref_clk), .nrst(nrst), .debug_mode_select_pin_in(pin),
      .debug_mode_select_pin_out(pout), .debug_mode_select_pin_oe(poe),
      .debug_mode_select_pin_pullup_en(ppu), .debug_pin_enable(dpe), .port_d_bit_zero(pd0),
      .tx_bit_start(txs), .tx_bit_val(txv), .tx_busy(busy), .rx_bit(rxb), .rx_valid(rxv),
      .halt_cmd(halt[0]), .halt_to_debug_instruction(halt[1]),
      .background_debug_controller_breakpoint(halt[2]),
      .trace_breakpoint_unit(halt[3]), .mem_rd(mrd), .mem_addr(maddr), .mem_rvalid(rv),
      .mem_rdata(rd), .cpu_start(cst), .cpu_start_pc(pc), .bg_mode(bg), .gpio_cfg_wr(wr),
      .gpio_cfg_oe(c_oe), .gpio_cfg_pu(c_pu), .gpio_oe(g_oe), .gpio_pullup_en(g_pu));
   rms_pod pod (.ref_clk(ref_clk), .hold_low(hold), .dev_oe(poe), .dev_out(pout),
      .dev_pu(ppu), .line(pin));
   initial forever #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (++cyc == 1000) results(1);
   // sampled mid-cycle so flop updates have landed
   always @(negedge ref_clk)
      if (rxv === 1'b1)
      begin
         // pop once: the compare macro reads its expected value twice
         exp_bit = q.pop_front();
         `CHK(rxb, exp_bit)
      end
   task automatic results(input int extra);
      failures += extra;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic boot(input logic low);
      nrst = 1'b0;
      hold = low;
      repeat (4) tick();
      `CHK({ppu, poe, g_oe, g_pu}, {2'b10, 74'h0})
      nrst = 1'b1;
      tick();
      hold = 1'b0;
      `CHK({bg, mrd, ppu, poe}, {low, ~low, 2'b10})
   endtask : boot
   task automatic fetch(input int s);
      logic [15:0] v;
      v = 16'($urandom());
      `CHK({mrd, maddr}, {1'b1, RMS_VEC_HI_ADDR})
      rv = 1'b1;
      rd = v[15:8];
      halt[s] = 1'b1;
      tick();
      halt = 4'h0;
      `CHK({mrd, maddr}, {1'b1, RMS_VEC_LO_ADDR})
      rd = v[7:0];
      tick();
      rv = 1'b0;
      tick();
      `CHK({cst, pc, bg}, {1'b1, v, 1'b0})
      tick();
      `CHK(cst, 1'b0)
   endtask : fetch
   initial
   begin
      void'($urandom(32'h2ccbb5ed));
      repeat (2) tick();
      for (int s = 0; s < 4; s++)
      begin
         boot(1'b0);
         fetch(s);
         c_oe = RMS_GPIO_N'({$urandom(), $urandom()});
         c_pu = RMS_GPIO_N'({$urandom(), $urandom()});
         wr = 1'b1;
         halt[s] = 1'b1;
         tick();
         wr = 1'b0;
         halt = 4'h0;
         `CHK({bg, g_oe, g_pu}, {1'b1, c_oe, c_pu})
         $display("test halt %0d done", s);
      end
      boot(1'b1);
      for (int k = 0; k < 6; k++)
      begin
         txv = (k < 2) ? 1'(k) : 1'($urandom());
         q.push_back(txv);
         txs = 1'b1;
         tick();
         txs = 1'b0;
         for (int i = 0; i < 20 && busy; i++) tick();
      end
      repeat (2) tick();
      `CHK(q.size(), 0)
      $display("test bits done");
      dpe = 1'b0;
      txs = 1'b1;
      repeat (4)
      begin
         pd0 = 1'($urandom());
         tick();
         `CHK({poe, ppu, pout, busy}, {2'b10, pd0, 1'b0})
      end
      txs = 1'b0;
      $display("test port done");
      results(0);
   end
endmodule : tb
`default_nettype wire
